// >>> pie_defs.svh
// Offsets, field positions, reset values and masks of the interrupt enable block
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH

// Register byte offsets on the APB bus
`define PIE_OFF_ENABLE_1 8'h00
`define PIE_OFF_ENABLE_2 8'h04
`define PIE_OFF_CORE_CTRL 8'h08
`define PIE_OFF_FLAGS_1 8'h0C
`define PIE_OFF_FLAGS_2 8'h10
`define PIE_OFF_FLAG_CLEAR 8'h14

// Reset values
`define PIE_ENABLE_RESET 8'h00
`define PIE_CTRL_RESET 8'h00
`define PIE_FLAG_RESET 8'h00

// Implemented bits of each byte
`define PIE_MASK_1 8'hFF
`define PIE_MASK_2 8'hF5
`define PIE_MASK_CTRL 8'hC0
`define PIE_MASK_CAPCMP2 8'h01

// Core control fields
`define PIE_BIT_GLOBAL 7
`define PIE_BIT_GROUP 6

// First enable register fields
`define PIE_BIT_EEPROM_DONE 7
`define PIE_BIT_ADC_DONE 6
`define PIE_BIT_SERIAL_RX 5
`define PIE_BIT_SERIAL_TX 4
`define PIE_BIT_SYNC_SERIAL 3
`define PIE_BIT_CAPCMP1 2
`define PIE_BIT_TIMER2_MATCH 1
`define PIE_BIT_TIMER1_OVERFLOW 0

// Second enable register fields
`define PIE_BIT_OSC_FAIL 7
`define PIE_BIT_COMPARATOR2 6
`define PIE_BIT_COMPARATOR1 5
`define PIE_BIT_LCD 4
`define PIE_BIT_LOW_VOLTAGE 2
`define PIE_BIT_CAPCMP2 0

`endif

// >>> pie_pkg.sv
// Types shared by the interrupt enable block
`default_nettype none
package pie_pkg;
  // One register byte
  typedef logic [7:0] pie_byte_t;
  // Register selected by an APB address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_ENABLE_1,
    SEL_ENABLE_2,
    SEL_CORE_CTRL,
    SEL_FLAGS_1,
    SEL_FLAGS_2,
    SEL_FLAG_CLEAR
  } pie_sel_t;
endpackage : pie_pkg
`default_nettype wire

// >>> pie_flag_bank.sv
// Bank of eight sticky interrupt flags, set by events, cleared by software
`default_nettype none
module pie_flag_bank #(
  parameter pie_pkg::pie_byte_t IMPL_MASK = 8'hFF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Events and clears
  input wire logic [7:0] set_pulse,
  input wire logic [7:0] clear_pulse,
  // Flag state
  output logic [7:0] flags
);

  // One sticky flag per bit; absent bits stay zero
  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (IMPL_MASK[i]) begin : g_impl
      // Set wins over a clear in the same cycle
      always_ff @(posedge clock) begin
        if (reset) begin
          flags[i] <= 1'b0;
        end else if (set_pulse[i]) begin
          flags[i] <= 1'b1;
        end else if (clear_pulse[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end else begin : g_absent
      assign flags[i] = 1'b0;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Event beats a same-cycle clear
  set_wins_a: assert property ((set_pulse & IMPL_MASK) != 8'h00 |=>
    (flags & $past(set_pulse) & IMPL_MASK) == ($past(set_pulse) & IMPL_MASK))
    else $error("flag event lost");

endmodule : pie_flag_bank
`default_nettype wire

// >>> pie_irq_gate.sv
// Combines flags, enables and the two group gates into one registered request
`default_nettype none
`include "pie_defs.svh"
module pie_irq_gate (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Flags and enables
  input wire logic [7:0] flags_1,
  input wire logic [7:0] flags_2,
  input wire logic [7:0] enable_1,
  input wire logic [7:0] enable_2,
  // Group gates
  input wire logic group_enable,
  input wire logic global_enable,
  // Request to core
  output logic irq
);

  logic source_hit;
  logic next_irq;

  // Any flagged source whose enable is set
  assign source_hit = |{flags_1 & enable_1, flags_2 & enable_2};
  // Group and global gates block every source
  assign next_irq = source_hit & group_enable & global_enable;

  // Registered level request
  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  irq_formula_a: assert property (##1 irq == $past(source_hit & group_enable & global_enable))
    else $error("request does not follow flags and enables");
  group_gate_a: assert property (!group_enable |=> !irq)
    else $error("request without group enable");
  osc_fail_a: assert property (flags_2[`PIE_BIT_OSC_FAIL] && enable_2[`PIE_BIT_OSC_FAIL]
    && group_enable && global_enable |=> irq)
    else $error("oscillator fail not delivered");
  comparator_a: assert property ((flags_2 & enable_2) == 8'h60 && group_enable
    && global_enable |=> irq)
    else $error("comparators not delivered");
  comp_mask_a: assert property ((flags_1 & enable_1) == 8'h00 && flags_2 == 8'h40
    && !enable_2[`PIE_BIT_COMPARATOR2] |=> !irq)
    else $error("masked comparator delivered");
  lcd_mask_a: assert property ((flags_1 & enable_1) == 8'h00 && flags_2 == 8'h10
    |=> irq == $past(enable_2[`PIE_BIT_LCD] & group_enable & global_enable))
    else $error("lcd gating wrong");
  low_volt_a: assert property ((flags_1 & enable_1) == 8'h00 && flags_2 == 8'h04
    |=> irq == $past(enable_2[`PIE_BIT_LOW_VOLTAGE] & group_enable & global_enable))
    else $error("low voltage gating wrong");
  capcmp2_a: assert property ((flags_1 & enable_1) == 8'h00 && flags_2 == 8'h01
    |=> irq == $past(enable_2[`PIE_BIT_CAPCMP2] & group_enable & global_enable))
    else $error("capture compare 2 gating wrong");
  timer1_a: assert property ((flags_2 & enable_2) == 8'h00 && flags_1 == 8'h01
    |=> irq == $past(enable_1[`PIE_BIT_TIMER1_OVERFLOW] & group_enable & global_enable))
    else $error("timer1 gating wrong");

endmodule : pie_irq_gate
`default_nettype wire

// >>> pie_top.sv
// Peripheral interrupt enable block with APB register access
//
// Register access over APB and the address map are this design's own decisions.
`default_nettype none
`include "pie_defs.svh"
// Contract
// - No source interrupts unless the peripheral group enable is also set.
// - First enable byte: eight read/write bits, zero at reset, fixed source order.
// - Second enable byte: six read/write bits, zero at reset, fixed positions.
// - Bits 3 and 1 of the second enable byte always read zero.
// - Oscillator fail enable passes or masks the oscillator fail interrupt.
// - Each comparator enable independently passes or masks its comparator interrupt.
// - LCD enable passes or masks the LCD interrupt.
// - Low voltage enable passes or masks the low voltage interrupt.
// - Capture compare 2 enable exists only on the larger variant.
// - Timer1 overflow enable passes or masks the timer1 overflow interrupt.
// - Flags set on their events regardless of any enable.
// - Group enable passes unmasked peripheral interrupts, or blocks them all.
// - Global enable passes unmasked interrupts, or blocks them all.
module pie_top #(
  parameter bit HAS_CAPCMP2 = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral event pulses
  input wire logic [7:0] events_1,
  input wire logic [7:0] events_2,
  // Interrupt request to the core
  output logic peripheral_irq
);

  // Implemented bits of the second byte for this variant
  localparam pie_pkg::pie_byte_t MASK_2 =
    HAS_CAPCMP2 ? `PIE_MASK_2 : (`PIE_MASK_2 & ~`PIE_MASK_CAPCMP2);

  pie_pkg::pie_byte_t enable_1;
  pie_pkg::pie_byte_t enable_2;
  pie_pkg::pie_byte_t core_ctrl;
  pie_pkg::pie_byte_t flags_1;
  pie_pkg::pie_byte_t flags_2;
  pie_pkg::pie_byte_t clear_1;
  pie_pkg::pie_byte_t clear_2;
  pie_pkg::pie_byte_t read_byte;
  pie_pkg::pie_sel_t sel;
  logic setup_phase;
  logic write_done;

  // Address decode of the word offsets
  function automatic pie_pkg::pie_sel_t decode(input logic [7:0] addr);
    case (addr)
      `PIE_OFF_ENABLE_1: decode = pie_pkg::SEL_ENABLE_1;
      `PIE_OFF_ENABLE_2: decode = pie_pkg::SEL_ENABLE_2;
      `PIE_OFF_CORE_CTRL: decode = pie_pkg::SEL_CORE_CTRL;
      `PIE_OFF_FLAGS_1: decode = pie_pkg::SEL_FLAGS_1;
      `PIE_OFF_FLAGS_2: decode = pie_pkg::SEL_FLAGS_2;
      `PIE_OFF_FLAG_CLEAR: decode = pie_pkg::SEL_FLAG_CLEAR;
      default: decode = pie_pkg::SEL_NONE;
    endcase
  endfunction : decode

  // Bus phase decode
  assign sel = decode(paddr);
  assign setup_phase = psel & ~penable;
  assign write_done = psel & penable & pready & pwrite;

  // Read mux; write-only clear reads zero
  always_comb begin
    case (sel)
      pie_pkg::SEL_ENABLE_1: read_byte = enable_1;
      pie_pkg::SEL_ENABLE_2: read_byte = enable_2;
      pie_pkg::SEL_CORE_CTRL: read_byte = core_ctrl;
      pie_pkg::SEL_FLAGS_1: read_byte = flags_1;
      pie_pkg::SEL_FLAGS_2: read_byte = flags_2;
      default: read_byte = 8'h00;
    endcase
  end

  // Answer one cycle after setup, with no wait state
  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= (sel == pie_pkg::SEL_NONE);
      prdata <= {24'h00_0000, read_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // First enable byte, all bits writable
  always_ff @(posedge clock) begin
    if (reset) begin
      enable_1 <= `PIE_ENABLE_RESET;
    end else if (write_done && pstrb[0] && sel == pie_pkg::SEL_ENABLE_1) begin
      enable_1 <= pwdata[7:0] & `PIE_MASK_1;
    end
  end

  // Second enable byte, unimplemented bits forced to zero
  always_ff @(posedge clock) begin
    if (reset) begin
      enable_2 <= `PIE_ENABLE_RESET;
    end else if (write_done && pstrb[0] && sel == pie_pkg::SEL_ENABLE_2) begin
      enable_2 <= pwdata[7:0] & MASK_2;
    end
  end

  // Core control: global and group enables only
  always_ff @(posedge clock) begin
    if (reset) begin
      core_ctrl <= `PIE_CTRL_RESET;
    end else if (write_done && pstrb[0] && sel == pie_pkg::SEL_CORE_CTRL) begin
      core_ctrl <= pwdata[7:0] & `PIE_MASK_CTRL;
    end
  end

  // Write-one-to-clear strobes, one byte lane per flag byte
  assign clear_1 = (write_done && pstrb[0] && sel == pie_pkg::SEL_FLAG_CLEAR) ?
    pwdata[7:0] : 8'h00;
  assign clear_2 = (write_done && pstrb[1] && sel == pie_pkg::SEL_FLAG_CLEAR) ?
    pwdata[15:8] : 8'h00;

  // Sticky flags of the first group
  pie_flag_bank #(
    .IMPL_MASK(`PIE_MASK_1)
  ) u_flags_1 (
    .clock(clock),
    .reset(reset),
    .set_pulse(events_1),
    .clear_pulse(clear_1),
    .flags(flags_1)
  );

  // Sticky flags of the second group
  pie_flag_bank #(
    .IMPL_MASK(MASK_2)
  ) u_flags_2 (
    .clock(clock),
    .reset(reset),
    .set_pulse(events_2),
    .clear_pulse(clear_2),
    .flags(flags_2)
  );

  // Gate flags by enables, group and global
  pie_irq_gate u_gate (
    .clock(clock),
    .reset(reset),
    .flags_1(flags_1),
    .flags_2(flags_2),
    .enable_1(enable_1),
    .enable_2(enable_2),
    .group_enable(core_ctrl[`PIE_BIT_GROUP]),
    .global_enable(core_ctrl[`PIE_BIT_GLOBAL]),
    .irq(peripheral_irq)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  en1_write_a: assert property (write_done && pstrb[0] && sel == pie_pkg::SEL_ENABLE_1
    |=> enable_1 == $past(pwdata[7:0]))
    else $error("first enable byte not written");
  en2_write_a: assert property (write_done && pstrb[0] && sel == pie_pkg::SEL_ENABLE_2
    |=> enable_2 == ($past(pwdata[7:0]) & MASK_2))
    else $error("second enable byte not written");
  en2_unimpl_a: assert property (setup_phase && sel == pie_pkg::SEL_ENABLE_2
    |=> prdata[3] == 1'b0 && prdata[1] == 1'b0)
    else $error("unimplemented enable bit read as one");
  flag_set_a: assert property (events_1 != 8'h00
    |=> (flags_1 & $past(events_1)) == $past(events_1))
    else $error("first group flag not set");
  flag_set2_a: assert property ((events_2 & MASK_2) != 8'h00
    |=> (flags_2 & $past(events_2) & MASK_2) == ($past(events_2) & MASK_2))
    else $error("second group flag not set");
  group_block_a: assert property (!core_ctrl[`PIE_BIT_GROUP] |=> !peripheral_irq)
    else $error("request with group enable clear");
  global_block_a: assert property (!core_ctrl[`PIE_BIT_GLOBAL] |=> !peripheral_irq)
    else $error("request with global enable clear");
  group_pass_a: assert property (core_ctrl[`PIE_BIT_GROUP] && core_ctrl[`PIE_BIT_GLOBAL]
    && (flags_1 & enable_1) != 8'h00 |=> peripheral_irq)
    else $error("unmasked request blocked");
  apb_answer_a: assert property (setup_phase |=> pready ##1 !pready || setup_phase)
    else $error("answer not one cycle after setup");

  irq_raised_c: cover property (!peripheral_irq ##1 peripheral_irq);
  clear_hit_c: cover property (write_done && sel == pie_pkg::SEL_FLAG_CLEAR
    && (clear_1 & flags_1) != 8'h00);
  set_clear_c: cover property ((events_1 & clear_1) != 8'h00);
  bad_addr_c: cover property (pready && pslverr);

endmodule : pie_top
`default_nettype wire

// >>> pie_periph_model.sv
// Model of the peripherals that raise interrupt events toward the block
`default_nettype none
module pie_periph_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Requests from the bench
  input wire logic [7:0] raise_1,
  input wire logic [7:0] raise_2,
  // Event pulses toward the block
  output logic [7:0] events_1,
  output logic [7:0] events_2
);
  timeunit 1ns;
  timeprecision 1ns;
  // One event cycle per requested cycle, quiet in reset
  always_ff @(posedge clock) begin
    if (reset) begin
      events_1 <= 8'h00;
      events_2 <= 8'h00;
    end else begin
      events_1 <= raise_1;
      events_2 <= raise_2;
    end
  end
endmodule : pie_periph_model
`default_nettype wire

// >>> peripheral_interrupt_enables_tb.sv
// Self-checking bench for the peripheral interrupt enable block
`default_nettype none
module peripheral_interrupt_enables_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] raise_1 = 8'h00;
  logic [7:0] raise_2 = 8'h00;
  logic [7:0] events_1;
  logic [7:0] events_2;
  logic peripheral_irq;
  int errors = 0;
  int cmp_count = 0;
  logic [7:0] m;
  logic [7:0] ea;

  // Clock generator
  always #10 clock = ~clock;

  pie_top u_pie_top (.clock(clock), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events_1(events_1), .events_2(events_2),
    .peripheral_irq(peripheral_irq));

  pie_periph_model u_pie_periph_model (.clock(clock), .reset(reset), .raise_1(raise_1),
    .raise_2(raise_2), .events_1(events_1), .events_2(events_2));

  // Verdict and end of run
  task automatic test_done();
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Compare one value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer, held until pready is seen
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock);
    end
    if (pready !== 1'b1) begin
      errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // Write with chosen strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, s, r, e);
  endtask : wr

  // Read and compare data and error response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, 4'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, experr});
  endtask : rd

  // Raise events for one cycle
  task automatic fire(input logic [7:0] e1, input logic [7:0] e2);
    raise_1 <= e1;
    raise_2 <= e2;
    @(posedge clock);
    raise_1 <= 8'h00;
    raise_2 <= 8'h00;
    @(posedge clock);
  endtask : fire

  // Let the request settle, then compare it
  task automatic irqchk(input logic exp);
    repeat (4) @(posedge clock);
    check({31'h0, peripheral_irq}, {31'h0, exp});
  endtask : irqchk

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'hFF);
    rd(8'h00, 32'hFF);
    wr(8'h00, 32'h00, 4'hE);
    rd(8'h00, 32'hFF);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'hF5);
    fire(8'hFF, 8'hFF);
    rd(8'h0C, 32'hFF);
    rd(8'h10, 32'hF5);
    wr(8'h0C, 32'h0);
    rd(8'h0C, 32'hFF);
    irqchk(1'b0);
    wr(8'h08, 32'h80);
    irqchk(1'b0);
    wr(8'h08, 32'h40);
    irqchk(1'b0);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'hC0);
    irqchk(1'b1);
    rd(8'h18, 32'h0, 1'b1);
    wr(8'h14, 32'hFFFF);
    rd(8'h14, 32'h0);
    irqchk(1'b0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    // Each source alone: flag set while masked, then unmasked, then cleared
    for (int k = 0; k < 16; k++) begin
      m = 8'h01 << k[2:0];
      ea = k[3] ? 8'h04 : 8'h00;
      fire(k[3] ? 8'h00 : m, k[3] ? m : 8'h00);
      irqchk(1'b0);
      wr(ea, {24'h0, m});
      irqchk(k[3] ? ((m & 8'hF5) != 8'h00) : 1'b1);
      wr(8'h14, k[3] ? {16'h0, m, 8'h00} : {24'h0, m});
      irqchk(1'b0);
      wr(ea, 32'h0);
    end
    // Event and clear in the same cycle: the event wins
    fork
      wr(8'h14, 32'h01);
      fire(8'h01, 8'h00);
    join
    rd(8'h0C, 32'h01);
    wr(8'h14, 32'h01);
    rd(8'h0C, 32'h0);
    // Reset in mid-run returns every register to zero
    wr(8'h00, 32'hA5);
    wr(8'h04, 32'hF5);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    check({31'h0, peripheral_irq}, 32'h0);
    test_done();
  end
endmodule : peripheral_interrupt_enables_tb
`default_nettype wire
